// file: smc_pkg.sv
// Purpose: Shared constants for the serializer mode and reference clock
//          configuration registers.
// Assumes: Registers are reached over an 8-bit internal register port.
// Notes:   Timing counts are derived from the 40 MHz system clock.
package smc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE     = 8'h03;
  localparam logic [7:0] ADDR_COMPAT   = 8'h04;
  localparam logic [7:0] ADDR_REFCLK   = 8'h05;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB      = 2;
  localparam int MODE_DONE_BIT = 3;
  localparam int OVERRIDE_BIT  = 4;
  localparam int MODE_RSV5_BIT = 5;
  localparam int MODE_RSV7_BIT = 7;
  localparam int RAW10_BIT     = 2;
  localparam int RAW12_BIT     = 1;
  localparam int LOCK_BIT      = 0;
  localparam int REFDIV_LSB    = 4;
  localparam int REFDIV_MSB    = 6;
  localparam int OSC_BIT       = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_REG_RST = 8'h00;
  localparam logic [7:0] COMPAT_RST   = 8'h00;
  localparam logic [7:0] REFCLK_RST   = 8'h03;
  localparam logic [2:0] STRAP_RST    = 3'h0;

  // ----------------------------------------------------------------------
  // Operating mode codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_CSI_SYNC = 3'h0;
  localparam logic [2:0] MODE_RSVD     = 3'h1;
  localparam logic [2:0] MODE_CSI_EXT  = 3'h2;
  localparam logic [2:0] MODE_CSI_INT  = 3'h3;
  localparam logic [2:0] MODE_PV_EXT   = 3'h5;

  // Power-up sequencing states
  typedef enum logic [1:0] {
    PWR_DOWN   = 2'b00,
    PWR_SETTLE = 2'b01,
    PWR_DONE   = 2'b10
  } smc_pwr_t;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ         = 40;
  localparam int MODE_SETTLE_NS  = 1000;
  localparam int MODE_SETTLE_CYC = (MODE_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CLK_LOSS_NS     = 6400;
  localparam int CLK_LOSS_CYC    = (CLK_LOSS_NS * CLK_MHZ + 999) / 1000;

  // Terminal count of the reference divider; reserved codes divide by 1
  function automatic logic [2:0] smc_div_last(input logic [2:0] sel);
    logic [2:0] last;
    last = 3'h0;
    if (sel == 3'h1) begin
      last = 3'h1;
    end else if (sel == 3'h2) begin
      last = 3'h3;
    end else if (sel == 3'h3) begin
      last = 3'h7;
    end
    return last;
  endfunction

endpackage

// file: smc_refdiv.sv
// Purpose: Divides reference clock edges into an internal reference tick.
// Assumes: ref_rise is a one-cycle pulse per reference clock rising edge.
// Notes:   Output tick is one system clock wide.
`timescale 1ns/1ps
module smc_refdiv (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       ref_rise,
  input  wire logic [2:0] div_sel,
  output logic            ref_tick
);
  import smc_pkg::*;

  logic [2:0] count;
  logic [2:0] last;

  // ----------------------------------------------------------------------
  // Edge counter
  // ----------------------------------------------------------------------
  // Decode divide ratio 1/2/4/8 into a terminal count
  assign last = smc_div_last(div_sel);

  // Restart on terminal count so a ratio change takes effect promptly
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count    <= 3'h0;
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= 1'b0;
      if (ref_rise) begin
        if (count >= last) begin
          count    <= 3'h0;
          ref_tick <= 1'b1;
        end else begin
          count <= count + 3'h1;
        end
      end
    end
  end

endmodule

// file: smc_mode_regs.sv
// Purpose: Mode selection and reference clock configuration registers.
// Assumes: Register port is driven by a local I2C target on this clock;
//          remote sub-mode loads arrive from control channel logic.
// Notes:   Strap and pin inputs are synchronised before use.
`timescale 1ns/1ps
module smc_mode_regs (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       power_down_n_pin,
  input  wire logic [2:0] mode_strap,
  input  wire logic       reference_clock_input,
  input  wire logic       bcc_rx_lock,
  input  wire logic       bcc_load_valid,
  input  wire logic       bcc_raw10,
  input  wire logic       bcc_raw12,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic      [2:0] op_mode,
  output logic            mode_done,
  output logic            mode_sync_csi,
  output logic            mode_nonsync_ext,
  output logic            mode_nonsync_int,
  output logic            mode_parallel_compat,
  output logic            raw10_compat_select,
  output logic            raw12_compat_select,
  output logic      [2:0] refclk_input_divider,
  output logic            internal_ref_tick,
  output logic            ext_clock_detected,
  output logic            use_internal_osc,
  output logic            oscillator_band_select
);
  import smc_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic       pwrdn_meta;
  logic       pwrdn_sync;
  logic       pwrdn_prev;
  logic       ref_meta;
  logic       ref_sync;
  logic       ref_prev;

  // Pins are asynchronous; edge detectors look only at the second stage and its delayed copy
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_meta <= STRAP_RST;
      strap_sync <= STRAP_RST;
      pwrdn_meta <= 1'b0;
      pwrdn_sync <= 1'b0;
      pwrdn_prev <= 1'b0;
      ref_meta   <= 1'b0;
      ref_sync   <= 1'b0;
      ref_prev   <= 1'b0;
    end else begin
      strap_meta <= mode_strap;
      strap_sync <= strap_meta;
      pwrdn_meta <= power_down_n_pin;
      pwrdn_sync <= pwrdn_meta;
      pwrdn_prev <= pwrdn_sync;
      ref_meta   <= reference_clock_input;
      ref_sync   <= ref_meta;
      ref_prev   <= ref_sync;
    end
  end

  wire pwrdn_rise = pwrdn_sync & ~pwrdn_prev;
  wire ref_rise = ref_sync & ~ref_prev;

  // ----------------------------------------------------------------------
  // Power-up mode latch
  // ----------------------------------------------------------------------
  smc_pwr_t   pwr_state;
  smc_pwr_t   next_pwr_state;
  logic [2:0] strap_latched;
  logic [7:0] settle_cnt;

  // Strap is sampled once per power-up, so later strap wiggles are ignored
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      PWR_DOWN: begin
        if (pwrdn_rise) begin
          next_pwr_state = PWR_SETTLE;
        end
      end
      PWR_SETTLE: begin
        if (!pwrdn_sync) begin
          next_pwr_state = PWR_DOWN;
        end else if (settle_cnt == 8'(MODE_SETTLE_CYC - 1)) begin
          next_pwr_state = PWR_DONE;
        end
      end
      PWR_DONE: begin
        if (!pwrdn_sync) begin
          next_pwr_state = PWR_DOWN;
        end
      end
      default: begin
        next_pwr_state = PWR_DOWN;
      end
    endcase
  end

  // State, settle timer and strap capture
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_state     <= PWR_DOWN;
      settle_cnt    <= 8'h00;
      strap_latched <= STRAP_RST;
    end else begin
      pwr_state <= next_pwr_state;
      if (pwr_state == PWR_SETTLE) begin
        settle_cnt <= settle_cnt + 8'h01;
      end else begin
        settle_cnt <= 8'h00;
      end
      if (pwr_state == PWR_DOWN && pwrdn_rise) begin
        strap_latched <= strap_sync;
      end
    end
  end

  assign mode_done = (pwr_state == PWR_DONE);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic       mode_rsv7;
  logic       mode_rsv5;
  logic       strap_override_enable;
  logic [2:0] mode_reg;
  logic [7:0] compat_reg;
  logic [7:0] refclk_reg;

  wire wr_mode   = reg_wr && (reg_addr == ADDR_MODE);
  wire wr_compat = reg_wr && (reg_addr == ADDR_COMPAT);
  wire wr_refclk = reg_wr && (reg_addr == ADDR_REFCLK);
  // Mode field accepts data only when the same write keeps override set
  wire wr_mode_field = wr_mode && reg_wdata[OVERRIDE_BIT];
  // Remote load is refused while software holds the lock bit
  wire remote_load = bcc_load_valid && bcc_rx_lock
                     && !compat_reg[LOCK_BIT];

  // Mode select register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_rsv7             <= MODE_REG_RST[MODE_RSV7_BIT];
      mode_rsv5             <= MODE_REG_RST[MODE_RSV5_BIT];
      strap_override_enable <= MODE_REG_RST[OVERRIDE_BIT];
      mode_reg              <= MODE_REG_RST[MODE_MSB:MODE_LSB];
    end else if (wr_mode) begin
      mode_rsv7             <= reg_wdata[MODE_RSV7_BIT];
      mode_rsv5             <= reg_wdata[MODE_RSV5_BIT];
      strap_override_enable <= reg_wdata[OVERRIDE_BIT];
      if (wr_mode_field) begin
        mode_reg <= reg_wdata[MODE_MSB:MODE_LSB];
      end
    end
  end

  // Sub-mode register; a local write wins over a remote load
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      compat_reg <= COMPAT_RST;
    end else if (wr_compat) begin
      compat_reg <= reg_wdata;
    end else if (remote_load) begin
      compat_reg[RAW10_BIT] <= bcc_raw10;
      compat_reg[RAW12_BIT] <= bcc_raw12;
    end
  end

  // Reference clock control register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refclk_reg <= REFCLK_RST;
    end else if (wr_refclk) begin
      refclk_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode and outputs
  // ----------------------------------------------------------------------
  // Field always shows the active mode: strap unless overridden
  assign op_mode = strap_override_enable ? mode_reg
                                         : strap_latched;
  assign mode_sync_csi        = (op_mode == MODE_CSI_SYNC);
  assign mode_nonsync_ext     = (op_mode == MODE_CSI_EXT);
  assign mode_nonsync_int     = (op_mode == MODE_CSI_INT);
  assign mode_parallel_compat = (op_mode == MODE_PV_EXT);
  assign raw10_compat_select  = compat_reg[RAW10_BIT];
  assign raw12_compat_select  = compat_reg[RAW12_BIT];
  assign refclk_input_divider = refclk_reg[REFDIV_MSB:REFDIV_LSB];
  assign oscillator_band_select = refclk_reg[OSC_BIT];

  // ----------------------------------------------------------------------
  // Reference clock presence and divider
  // ----------------------------------------------------------------------
  logic [8:0] loss_cnt;

  // Counts cycles since the last reference edge, saturating at the limit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      loss_cnt <= 9'(CLK_LOSS_CYC);
    end else if (ref_rise) begin
      loss_cnt <= 9'h000;
    end else if (loss_cnt < 9'(CLK_LOSS_CYC)) begin
      loss_cnt <= loss_cnt + 9'h001;
    end
  end

  assign ext_clock_detected = (loss_cnt < 9'(CLK_LOSS_CYC));
  // Oscillator takes over for always-on mode or a missing clock
  assign use_internal_osc = mode_nonsync_int
                            || !ext_clock_detected;

  smc_refdiv u_refdiv (
    .clock    (clock),
    .arst_n   (arst_n),
    .ref_rise (ref_rise),
    .div_sel  (refclk_input_divider),
    .ref_tick (internal_ref_tick)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire [7:0] mode_rd_val = {mode_rsv7, 1'b0, mode_rsv5,
                            strap_override_enable, mode_done, op_mode};
  wire [7:0] rd_mux = (reg_addr == ADDR_MODE)     ? mode_rd_val :
                      (reg_addr == ADDR_COMPAT)   ? compat_reg  :
                      (reg_addr == ADDR_REFCLK)   ? refclk_reg  :
                                                    8'h00;

  // Read data registered one cycle after the strobe, held until next read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule

// file: smc_bcc_model.sv
// Purpose: Far end of the control channel that loads the sub-mode bits.
// Assumes: Commands come from the bench on the system clock.
// Notes:   Load data lines carry junk outside the one-cycle load pulse.
`timescale 1ns/1ps
module smc_bcc_model (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       link_up,
  input  wire logic       send,
  input  wire logic [1:0] bits,
  input  wire logic [3:0] lag,
  output logic            bcc_rx_lock,
  output logic            bcc_load_valid,
  output logic            bcc_raw10,
  output logic            bcc_raw12
);
  logic [4:0] wait_cnt;
  logic [1:0] held;

  // Lag lets the far end answer at once or some cycles late
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= 5'h00;
      held     <= 2'h0;
    end else if (send) begin
      wait_cnt <= {1'b0, lag} + 5'h01;
      held     <= bits;
    end else if (wait_cnt != 5'h00) begin
      wait_cnt <= wait_cnt - 5'h01;
    end
  end

  // Stale data is inverted so nothing passes by luck
  assign bcc_rx_lock    = link_up;
  assign bcc_load_valid = (wait_cnt == 5'h01);
  assign {bcc_raw10, bcc_raw12} = bcc_load_valid ? held : ~held;
endmodule

// file: smc_mode_regs_asserts.sv
// Purpose: Port-level checks of the mode and reference clock registers.
// Assumes: Sees only the ports of smc_mode_regs.
// Notes:   The lock bit is mirrored from register writes.
`timescale 1ns/1ps
module smc_mode_regs_asserts import smc_pkg::*; (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       power_down_n_pin,
  input wire logic       bcc_rx_lock,
  input wire logic       bcc_load_valid,
  input wire logic       bcc_raw10,
  input wire logic       bcc_raw12,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] op_mode,
  input wire logic       mode_done,
  input wire logic       mode_sync_csi,
  input wire logic       mode_nonsync_ext,
  input wire logic       mode_nonsync_int,
  input wire logic       mode_parallel_compat,
  input wire logic       raw10_compat_select,
  input wire logic       raw12_compat_select,
  input wire logic [2:0] refclk_input_divider,
  input wire logic       ext_clock_detected,
  input wire logic       use_internal_osc,
  input wire logic       oscillator_band_select
);
  logic lock_q;
  logic wr4;

  // Mirror of the lock bit, needed to know when loads must be refused
  assign wr4 = reg_wr && (reg_addr == ADDR_COMPAT);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 1'b0;
    end else if (wr4) begin
      lock_q <= reg_wdata[LOCK_BIT];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence pin_up_s;
    $rose(power_down_n_pin) ##1 power_down_n_pin[*4];
  endsequence
  // Flag stays low for 36 cycles after the pin has held high, not only at the start of the settle time
  sequence settle_s;
    !mode_done[*8] ##1 !mode_done[*8] ##1 !mode_done[*8]
    ##1 !mode_done[*8] ##1 !mode_done[*4] ##[1:5] mode_done;
  endsequence
  sequence load_s;
    bcc_load_valid && bcc_rx_lock && !lock_q && !wr4;
  endsequence

  mode_write_a: assert property (
    reg_wr && reg_addr == ADDR_MODE && reg_wdata[OVERRIDE_BIT]
    |=> op_mode == $past(reg_wdata[2:0])) else $error("mode write lost");
  mode_decode_a: assert property (
    {mode_parallel_compat, mode_nonsync_int, mode_nonsync_ext, mode_sync_csi}
    == {op_mode == MODE_PV_EXT, op_mode == MODE_CSI_INT,
        op_mode == MODE_CSI_EXT, op_mode == MODE_CSI_SYNC})
    else $error("mode decode wrong");
  mode_read_a: assert property (
    reg_rd && reg_addr == ADDR_MODE |=> reg_rdata[2:0] == $past(op_mode)
    && reg_rdata[3] == $past(mode_done) && !reg_rdata[6])
    else $error("mode readback wrong");
  remote_load_a: assert property (
    load_s |=> {raw10_compat_select, raw12_compat_select}
    == $past({bcc_raw10, bcc_raw12})) else $error("remote load lost");
  load_block_a: assert property (
    bcc_load_valid && lock_q && !wr4
    |=> $stable({raw10_compat_select, raw12_compat_select}))
    else $error("locked bits changed");
  refclk_write_a: assert property (
    reg_wr && reg_addr == ADDR_REFCLK |=> refclk_input_divider ==
    $past(reg_wdata[6:4]) && oscillator_band_select == $past(reg_wdata[3]))
    else $error("refclk fields wrong");
  osc_use_a: assert property (
    use_internal_osc == (op_mode == MODE_CSI_INT || !ext_clock_detected))
    else $error("oscillator use wrong");
  power_settle_a: assert property (
    pin_up_s |-> settle_s) else $error("settle flag timing wrong");
  done_drop_a: assert property (
    $fell(power_down_n_pin) ##1 !power_down_n_pin[*4] |-> !mode_done)
    else $error("settle flag stuck");
endmodule

bind smc_mode_regs smc_mode_regs_asserts u_chk (.*);

// file: smc_mode_regs_bench.sv
// Purpose: Self-checking bench for the mode and refclk registers.
// Assumes: Register port is the design's internal byte port.
// Notes:   Random values come from one fixed seed.
`timescale 1ns/1ps
module smc_mode_regs_bench;
  import smc_pkg::*;
  logic       clock, arst_n, power_down_n_pin, reference_clock_input;
  logic       reg_wr, reg_rd, link_up, send, mode_done, ext_clock_detected;
  logic       mode_sync_csi, mode_nonsync_ext, mode_nonsync_int;
  logic       mode_parallel_compat, raw10_compat_select, raw12_compat_select;
  logic       internal_ref_tick, use_internal_osc, oscillator_band_select;
  logic       bcc_rx_lock, bcc_load_valid, bcc_raw10, bcc_raw12;
  logic [1:0] bits;
  logic [2:0] mode_strap, op_mode, refclk_input_divider, strap, code;
  logic [3:0] lag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
  int         n_errors, checked, cyc, ticks, k, t;

  smc_mode_regs u_dut (.*);
  smc_bcc_model u_far (.*);

  always #12.5 clock = ~clock;

  // Count ticks away from the edge that launches them
  always @(negedge clock) if (internal_ref_tick === 1'b1) ticks++;

  // Hang guard, far above the under two thousand cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("[ERR] %0t run hung", $time);
      conclude();
    end
  end

  function automatic logic [7:0] dec(input logic [2:0] m);
    return {4'h0, m == 3'h5, m == 3'h3, m == 3'h2, m == 3'h0};
  endfunction
  function automatic logic [7:0] exp_ticks(input logic [2:0] c);
    return (c > 3'h3) ? 8'h10 : 8'h10 >> c; // reserved codes pass through
  endfunction

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    tick();
    reg_wr    = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    tick();
    reg_rd   = 1'b0;
    tick();
    chk(reg_rdata, exp);
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {clock, arst_n, power_down_n_pin, reference_clock_input} = 4'h0;
    {reg_wr, reg_rd, link_up, send, bits, lag} = 10'h000;
    {reg_addr, reg_wdata, rv} = 24'h000000;
    {n_errors, checked, cyc, ticks} = 128'h0;
    void'($urandom(32'h9da74cd8));
    strap = 3'h5;
    mode_strap = strap;
    tick(16);
    arst_n = 1'b1;
    rd(ADDR_MODE, 8'h00);
    rd(ADDR_COMPAT, 8'h00);
    rd(ADDR_REFCLK, 8'h03);
    rd(8'h06 + 8'($urandom_range(0, 249)), 8'h00);
    // Power-up latches the strap, later pin changes must not leak in
    power_down_n_pin = 1'b1;
    t = 0;
    while (mode_done !== 1'b1 && t < 100) begin
      tick();
      t++;
    end
    mode_strap = ~strap;
    chk(8'(t >= 40 && t <= 46), 8'h01);
    rd(ADDR_MODE, {5'h01, strap});
    wr(ADDR_MODE, {5'h00, ~strap});
    rd(ADDR_MODE, {5'h01, strap});
    // Override with each non-reserved mode code and one random code, odd bits random
    for (k = 0; k < 5; k++) begin
      code = (k == 4) ? 3'($urandom) : codes[k];
      rv = (8'($urandom) & 8'hE8) | 8'h10 | {5'h00, code};
      wr(ADDR_MODE, rv);
      rd(ADDR_MODE, (rv & 8'hB7) | 8'h08);
      chk({4'h0, mode_parallel_compat, mode_nonsync_int, mode_nonsync_ext,
           mode_sync_csi}, dec(code));
    end
    wr(ADDR_MODE, 8'h12);
    // Every divider code, ascending so the divider starts in phase
    for (k = 0; k < 8; k++) begin
      rv = {1'($urandom), 3'(k), 4'($urandom)};
      wr(ADDR_REFCLK, rv);
      rd(ADDR_REFCLK, rv);
      ticks = 0;
      repeat (16) begin
        reference_clock_input = 1'b1;
        tick(4);
        reference_clock_input = 1'b0;
        tick(4);
      end
      chk(8'(ticks), exp_ticks(3'(k)));
    end
    chk({6'h00, ext_clock_detected, use_internal_osc}, 8'h02);
    tick(300);
    chk({6'h00, ext_clock_detected, use_internal_osc}, 8'h01);
    // Remote loads: prompt, late, refused without link, refused when locked
    rv = 8'h00;
    for (k = 0; k < 6; k++) begin
      bits = 2'($urandom);
      lag = (k == 0) ? 4'h0 : 4'($urandom);
      link_up = (k != 3);
      if (k == 5) wr(ADDR_COMPAT, {5'h00, ~bits, 1'b1});
      send = 1'b1;
      tick();
      send = 1'b0;
      tick(20);
      if (k == 5) rv = {5'h00, ~bits, 1'b1};
      else if (k != 3) rv = {5'h00, bits, 1'b0};
      rd(ADDR_COMPAT, rv);
      chk({6'h00, raw10_compat_select, raw12_compat_select},
          {6'h00, rv[2:1]});
    end
    // Second power cycle with a fresh strap and override off
    power_down_n_pin = 1'b0;
    tick(6);
    chk({7'h00, mode_done}, 8'h00);
    wr(ADDR_MODE, 8'h00);
    strap = 3'($urandom);
    mode_strap = strap;
    tick(10);
    power_down_n_pin = 1'b1;
    tick(50);
    rd(ADDR_MODE, {5'h01, strap});
    conclude();
  end
endmodule
